/* rtl/parallel_io_master_port_defs.svh */
// Constants of the parallel master-communication port: offsets, fields, resets and timing.
// Operation
// - Protocol selector reads 15 while port active.
// - Sixteen input lines and sixteen output lines.
// - Input line functions freely assignable by configuration.
// - Output line functions freely assignable by configuration.
// - Port active after reset without configuration.
// - Active port without supply raises supply fault.
// - Writing 2 deactivates port, suppresses fault.
// - Deactivated words detach from pins, stay accessible.
// - Controller must give enable edge; level insufficient.
// - Enable input routed into control word bit.
// - Edge accepted: no error, phase 4, DC ok.
// - Edge accepted only with ready status bit 1.
// - Enable with halt input low holds halted.
// - Halt input high leaves halt, mode active.
// - Halted reports halt diagnostic and panel codes.
// - Clear-error rising edge launches clearing once.
// - Clearing command clears every pending drive error.
// - Default configuration assigns clearing to input.
// - Control word refreshed every 250 or 500 us.
// - Input line n captured into word bit n.
`ifndef PARALLEL_IO_MASTER_PORT_DEFS_SVH
`define PARALLEL_IO_MASTER_PORT_DEFS_SVH
`define PIO_OFS_PROTOCOL 8'h00
`define PIO_OFS_CTRL_WORD 8'h04
`define PIO_OFS_STAT_WORD 8'h08
`define PIO_OFS_IN_MAP 8'h0C
`define PIO_OFS_OUT_SEL_LO 8'h10
`define PIO_OFS_OUT_SEL_HI 8'h14
`define PIO_OFS_DRIVE 8'h18
`define PIO_PROTO_ACTIVE 8'h0F
`define PIO_PROTO_OFF 8'h02
`define PIO_PROTO_RST 8'h0F
`define PIO_IN_MAP_RST 12'hCBA
`define PIO_MAP_EN_LSB 0
`define PIO_MAP_HALT_LSB 4
`define PIO_MAP_CLR_LSB 8
`define PIO_OUT_SEL_LO_RST 32'h76543210
`define PIO_OUT_SEL_HI_RST 32'hFEDCBA98
`define PIO_PHASE_RUN 3'h4
`define PIO_READY_BIT 1
`define PIO_HALT_DIAG 20'hA0010
`define PIO_RUN_DIAG 20'h00000
`define PIO_CLK_NS 10
`define PIO_ADV_CYCLE_US 250
`define PIO_BASIC_CYCLE_US 500
`define PIO_ADV_CYCLES (`PIO_ADV_CYCLE_US * 1000 / `PIO_CLK_NS)
`define PIO_BASIC_CYCLES (`PIO_BASIC_CYCLE_US * 1000 / `PIO_CLK_NS)
`endif

/* rtl/parallel_io_master_port_pkg.sv */
// Types shared by the parallel master-communication port.
package parallel_io_master_port_pkg;
    typedef enum logic [2:0] {
        DRIVE_OFF = 3'b001,
        DRIVE_HALTED = 3'b010,
        DRIVE_RUN = 3'b100
    } drive_state_t;

    typedef enum logic [3:0] {
        PANEL_IDLE = 4'b0001,
        READY_PANEL_CODE = 4'b0010,
        HALT_PANEL_CODE = 4'b0100,
        RUNNING_PANEL_CODE = 4'b1000
    } panel_code_t;

    typedef struct packed {
        logic error_pending;
        logic [2:0] phase;
        logic dc_bus_ok;
        logic [15:0] device_status;
    } drive_cond_t;

    typedef struct packed {
        logic energized;
        logic halted;
        logic op_mode_active;
        logic [19:0] halt_diagnostic_code;
        panel_code_t panel;
    } drive_report_t;
endpackage

/* rtl/parallel_io_master_port.sv */
// Parallel master-communication port: input sampling, drive enable, halt, error clear, status outputs.
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "parallel_io_master_port_defs.svh"
module parallel_io_master_port #(
    parameter int ADV_CYCLES = `PIO_ADV_CYCLES,
    parameter int BASIC_CYCLES = `PIO_BASIC_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [15:0] port_in_i,
    input wire logic port_supply_ok_i,
    output logic [15:0] port_out_o,
    input wire logic basic_variant_i,
    input wire parallel_io_master_port_pkg::drive_cond_t drive_cond_i,
    output parallel_io_master_port_pkg::drive_report_t drive_report_o,
    output logic error_clear_command_o,
    output logic external_supply_fault_o
);
    generate
        if (ADV_CYCLES < 2 || BASIC_CYCLES < 2 || ADV_CYCLES > 65536 || BASIC_CYCLES > 65536)
        begin : g_bad_cycles
            $error("Cycle counts must lie between 2 and 65536.");
        end
    endgenerate

    localparam logic [15:0] ADV_LAST = 16'(ADV_CYCLES - 1);
    localparam logic [15:0] BASIC_LAST = 16'(BASIC_CYCLES - 1);

    logic [15:0] in_meta;
    logic [15:0] in_sync;
    logic supply_meta;
    logic supply_sync;
    logic [7:0] protocol;
    logic [15:0] ctrl_word;
    logic [15:0] prev_ctrl;
    logic [15:0] stat_word;
    logic [11:0] in_map;
    logic [63:0] out_sel;
    logic [15:0] tick_cnt;
    logic tick;
    logic eval;
    logic port_active;
    logic bus_req;
    logic bus_wr;
    logic [31:0] wmask;
    logic en_level;
    logic en_rise;
    logic halt_level;
    logic clr_rise;
    logic accept;
    logic [15:0] status_src;
    logic [15:0] next_out;
    parallel_io_master_port_pkg::drive_state_t drive_state;
    parallel_io_master_port_pkg::drive_state_t next_drive_state;

    // Pins come from another domain, so both pass two flip-flops before use.
    always_ff @(posedge clk_i)
    begin
        in_meta <= port_in_i;
        in_sync <= in_meta;
        supply_meta <= port_supply_ok_i;
        supply_sync <= supply_meta;
    end

    // Cycle tick; the variant selects the refresh period.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tick_cnt <= 16'h0000;
        end
        else if (tick)
        begin
            tick_cnt <= 16'h0000;
        end
        else
        begin
            tick_cnt <= tick_cnt + 16'h0001;
        end
    end
    assign tick = tick_cnt >= (basic_variant_i ? BASIC_LAST : ADV_LAST);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            eval <= 1'b0;
        end
        else
        begin
            eval <= tick;
        end
    end

    assign port_active = protocol == `PIO_PROTO_ACTIVE;
    assign bus_req = cyc_i && stb_i && !ack_o;
    assign bus_wr = bus_req && we_i;
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            protocol <= `PIO_PROTO_RST;
            in_map <= `PIO_IN_MAP_RST;
            out_sel <= {`PIO_OUT_SEL_HI_RST, `PIO_OUT_SEL_LO_RST};
        end
        else if (bus_wr)
        begin
            if (adr_i == `PIO_OFS_PROTOCOL && sel_i[0])
            begin
                protocol <= dat_i[7:0];
            end
            if (adr_i == `PIO_OFS_IN_MAP)
            begin
                in_map <= (in_map & ~wmask[11:0]) | (dat_i[11:0] & wmask[11:0]);
            end
            if (adr_i == `PIO_OFS_OUT_SEL_LO)
            begin
                out_sel[31:0] <= (out_sel[31:0] & ~wmask) | (dat_i & wmask);
            end
            if (adr_i == `PIO_OFS_OUT_SEL_HI)
            begin
                out_sel[63:32] <= (out_sel[63:32] & ~wmask) | (dat_i & wmask);
            end
        end
    end

    // While active the pins own the control word; software writes only reach it once detached.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_word <= 16'h0000;
            prev_ctrl <= 16'h0000;
        end
        else
        begin
            if (tick)
            begin
                prev_ctrl <= ctrl_word;
            end
            if (port_active && tick)
            begin
                ctrl_word <= in_sync;
            end
            else if (!port_active && bus_wr && adr_i == `PIO_OFS_CTRL_WORD)
            begin
                ctrl_word <= (ctrl_word & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stat_word <= 16'h0000;
        end
        else if (bus_wr && adr_i == `PIO_OFS_STAT_WORD)
        begin
            stat_word <= (stat_word & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
        end
    end

    assign en_level = ctrl_word[in_map[`PIO_MAP_EN_LSB +: 4]];
    assign halt_level = ctrl_word[in_map[`PIO_MAP_HALT_LSB +: 4]];
    assign en_rise = en_level && !prev_ctrl[in_map[`PIO_MAP_EN_LSB +: 4]];
    assign clr_rise = ctrl_word[in_map[`PIO_MAP_CLR_LSB +: 4]] && !prev_ctrl[in_map[`PIO_MAP_CLR_LSB +: 4]];
    assign accept = !drive_cond_i.error_pending && drive_cond_i.phase == `PIO_PHASE_RUN
        && drive_cond_i.dc_bus_ok && drive_cond_i.device_status[`PIO_READY_BIT];

    always_comb
    begin
        next_drive_state = drive_state;
        if (eval)
        begin
            unique case (drive_state)
                parallel_io_master_port_pkg::DRIVE_OFF:
                begin
                    if (en_rise && accept)
                    begin
                        next_drive_state = halt_level ? parallel_io_master_port_pkg::DRIVE_RUN
                            : parallel_io_master_port_pkg::DRIVE_HALTED;
                    end
                end
                parallel_io_master_port_pkg::DRIVE_HALTED,
                parallel_io_master_port_pkg::DRIVE_RUN:
                begin
                    if (!en_level || drive_cond_i.error_pending)
                    begin
                        next_drive_state = parallel_io_master_port_pkg::DRIVE_OFF;
                    end
                    else if (halt_level)
                    begin
                        next_drive_state = parallel_io_master_port_pkg::DRIVE_RUN;
                    end
                    else
                    begin
                        next_drive_state = parallel_io_master_port_pkg::DRIVE_HALTED;
                    end
                end
                default:
                begin
                    next_drive_state = parallel_io_master_port_pkg::DRIVE_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            drive_state <= parallel_io_master_port_pkg::DRIVE_OFF;
        end
        else
        begin
            drive_state <= next_drive_state;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            drive_report_o <= '{1'b0, 1'b0, 1'b0, `PIO_RUN_DIAG, parallel_io_master_port_pkg::PANEL_IDLE};
        end
        else
        begin
            drive_report_o.energized <= next_drive_state != parallel_io_master_port_pkg::DRIVE_OFF;
            drive_report_o.halted <= next_drive_state == parallel_io_master_port_pkg::DRIVE_HALTED;
            drive_report_o.op_mode_active <= next_drive_state == parallel_io_master_port_pkg::DRIVE_RUN;
            unique case (next_drive_state)
                parallel_io_master_port_pkg::DRIVE_HALTED:
                begin
                    drive_report_o.halt_diagnostic_code <= `PIO_HALT_DIAG;
                    drive_report_o.panel <= parallel_io_master_port_pkg::HALT_PANEL_CODE;
                end
                parallel_io_master_port_pkg::DRIVE_RUN:
                begin
                    drive_report_o.halt_diagnostic_code <= `PIO_RUN_DIAG;
                    drive_report_o.panel <= parallel_io_master_port_pkg::RUNNING_PANEL_CODE;
                end
                default:
                begin
                    drive_report_o.halt_diagnostic_code <= `PIO_RUN_DIAG;
                    drive_report_o.panel <= accept ? parallel_io_master_port_pkg::READY_PANEL_CODE
                        : parallel_io_master_port_pkg::PANEL_IDLE;
                end
            endcase
        end
    end

    // One pulse per edge; the drive core clears all pending errors on it, not only port ones.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            error_clear_command_o <= 1'b0;
        end
        else
        begin
            error_clear_command_o <= eval && clr_rise;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            external_supply_fault_o <= 1'b0;
        end
        else
        begin
            external_supply_fault_o <= port_active && !supply_sync;
        end
    end

    assign status_src = {stat_word[15:8], drive_cond_i.dc_bus_ok, port_active, drive_cond_i.error_pending,
        external_supply_fault_o, drive_report_o.op_mode_active, drive_report_o.halted,
        drive_report_o.energized, accept};

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_out_mux
            assign next_out[gi] = status_src[out_sel[4 * gi +: 4]];
        end
    endgenerate

    // Detached outputs read low so the controller sees no stale status.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            port_out_o <= 16'h0000;
        end
        else if (!port_active)
        begin
            port_out_o <= 16'h0000;
        end
        else if (tick)
        begin
            port_out_o <= next_out;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end
        else
        begin
            ack_o <= bus_req;
            dat_o <= 32'h00000000;
            if (bus_req && !we_i)
            begin
                unique case (adr_i)
                    `PIO_OFS_PROTOCOL: dat_o <= {24'h000000, protocol};
                    `PIO_OFS_CTRL_WORD: dat_o <= {16'h0000, ctrl_word};
                    `PIO_OFS_STAT_WORD: dat_o <= {16'h0000, port_active ? port_out_o : stat_word};
                    `PIO_OFS_IN_MAP: dat_o <= {20'h00000, in_map};
                    `PIO_OFS_OUT_SEL_LO: dat_o <= out_sel[31:0];
                    `PIO_OFS_OUT_SEL_HI: dat_o <= out_sel[63:32];
                    `PIO_OFS_DRIVE: dat_o <= {26'h0000000, drive_state, drive_report_o.energized,
                        external_supply_fault_o, port_active};
                    default: dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence

    sequence s_en_edge_ok;
        eval && drive_state == parallel_io_master_port_pkg::DRIVE_OFF && en_rise && accept;
    endsequence

    a_bus_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
        s_req |=> ack_o ##1 !ack_o) else $error("Bus ack not a single pulse one cycle after request.");

    a_supply_fault_set: assert property (@(posedge clk_i) disable iff (rst_i)
        port_active && !supply_sync |=> external_supply_fault_o) else $error("Supply fault missing.");

    a_off_no_fault: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(protocol) == `PIO_PROTO_OFF |-> !external_supply_fault_o) else $error("Fault while port off.");

    a_level_no_energize: assert property (@(posedge clk_i) disable iff (rst_i)
        drive_state == parallel_io_master_port_pkg::DRIVE_OFF && !(eval && en_rise)
        |=> drive_state == parallel_io_master_port_pkg::DRIVE_OFF) else $error("Energized without edge.");

    a_accept_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        drive_state == parallel_io_master_port_pkg::DRIVE_OFF && eval && en_rise && !accept
        |=> drive_state == parallel_io_master_port_pkg::DRIVE_OFF) else $error("Edge accepted while not ready.");

    a_edge_energize: assert property (@(posedge clk_i) disable iff (rst_i)
        s_en_edge_ok |=> drive_state != parallel_io_master_port_pkg::DRIVE_OFF ##1 drive_report_o.energized)
        else $error("Valid enable edge not taken.");

    a_halt_report: assert property (@(posedge clk_i) disable iff (rst_i)
        drive_state == parallel_io_master_port_pkg::DRIVE_HALTED |-> drive_report_o.halted
        && drive_report_o.halt_diagnostic_code == `PIO_HALT_DIAG
        && drive_report_o.panel == parallel_io_master_port_pkg::HALT_PANEL_CODE) else $error("Halt report wrong.");

    a_halt_release: assert property (@(posedge clk_i) disable iff (rst_i)
        drive_state == parallel_io_master_port_pkg::DRIVE_HALTED && eval && en_level && halt_level
        && !drive_cond_i.error_pending |=> drive_state == parallel_io_master_port_pkg::DRIVE_RUN ##1
        drive_report_o.op_mode_active) else $error("Halt not released.");

    a_clear_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        eval && clr_rise |=> error_clear_command_o ##1 !error_clear_command_o) else $error("Clear pulse wrong.");

    a_detached_out: assert property (@(posedge clk_i) disable iff (rst_i)
        !port_active |=> port_out_o == 16'h0000) else $error("Outputs driven while detached.");

    a_capture_map: assert property (@(posedge clk_i) disable iff (rst_i)
        port_active && tick |=> ctrl_word == $past(in_sync)) else $error("Input capture wrong.");
endmodule
`default_nettype wire

/* testbench/io_controller_model.sv */
// Behavioural external controller that drives the discrete input lines and the port supply.
`timescale 1ns/10ps
`default_nettype none
module io_controller_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] want_i,
    input wire logic supply_i,
    input wire logic [3:0] lag_i,
    output logic [15:0] port_o,
    output logic supply_ok_o
);
    logic [3:0] wait_n;
    // A new pattern reaches the lines only after lag_i cycles, so a slow output stage is covered too.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (want_i != port_o && wait_n >= lag_i))
        begin
            port_o <= want_i;
            wait_n <= 4'h0;
        end
        else if (want_i != port_o)
        begin
            wait_n <= wait_n + 4'h1;
        end
    end
    always_ff @(posedge clk_i)
    begin
        supply_ok_o <= supply_i;
    end
endmodule
`default_nettype wire

/* testbench/tb_parallel_io_master_port.sv */
// Self-checking bench for the parallel master-communication port.
`timescale 1ns/10ps
`default_nettype none
module tb_parallel_io_master_port;
    localparam parallel_io_master_port_pkg::drive_cond_t GOOD = '{1'h0, 3'h4, 1'h1, 16'h0002};
    logic clk_i;
    logic rst_i;
    logic cyc, stb, we, supply, supply_ok, basic, ack_o, clr_o, fault_o;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [3:0] lag;
    logic [31:0] wdat;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic [15:0] pins;
    logic [15:0] port_in;
    logic [15:0] port_out_o;
    parallel_io_master_port_pkg::drive_cond_t cond;
    parallel_io_master_port_pkg::drive_report_t rep;
    int fail_count;
    int comparisons;

    parallel_io_master_port #(.ADV_CYCLES(8), .BASIC_CYCLES(16)) parallel_io_master_port_i (.clk_i(clk_i),
        .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(dat_o), .ack_o(ack_o), .port_in_i(port_in), .port_supply_ok_i(supply_ok),
        .port_out_o(port_out_o), .basic_variant_i(basic), .drive_cond_i(cond), .drive_report_o(rep),
        .error_clear_command_o(clr_o), .external_supply_fault_o(fault_o));
    io_controller_model io_controller_model_i (.clk_i(clk_i), .rst_i(rst_i), .want_i(pins),
        .supply_i(supply), .lag_i(lag), .port_o(port_in), .supply_ok_o(supply_ok));

    initial
    begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task stop_test;
        $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // The master holds the whole request until it samples ack, then idles one cycle.
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'h1 && n < 20);
        rd = dat_o;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
        @(posedge clk_i);
        if (n >= 20)
        begin
            fail_count++;
            stop_test;
        end
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        wb(1'h0, a, 32'h00000000);
        check(rd, e);
    endtask

    // Long enough for lag, synchroniser, one tick and evaluation in either variant.
    task settle;
        repeat (basic ? 64 : 32) @(posedge clk_i);
    endtask

    task en_edge;
        pins[10] <= 1'h0;
        settle;
        pins[10] <= 1'h1;
        settle;
    endtask

    task wait_fault(input logic e);
        int n;
        n = 0;
        while (fault_o !== e && n < 100)
        begin
            @(posedge clk_i);
            n++;
        end
        check(32'(fault_o), 32'(e));
        if (fault_o !== e)
        begin
            stop_test;
        end
    endtask

    task t_reset;
        rd_chk(8'h00, 32'h0000000F);
        rd_chk(8'h0C, 32'h00000CBA);
        rd_chk(8'h10, 32'h76543210);
        rd_chk(8'h14, 32'hFEDCBA98);
        check(32'(rep.panel), 32'(parallel_io_master_port_pkg::READY_PANEL_CODE));
        wait_fault(1'h1);
        supply <= 1'h1;
        wait_fault(1'h0);
        $display("test reset done");
    endtask

    task t_capture;
        cond.error_pending <= 1'h1;
        for (int i = 0; i < 16; i++)
        begin
            basic <= (i >= 8);
            pins <= 16'h0001 << i;
            settle;
            rd_chk(8'h04, 32'h00000001 << i);
        end
        basic <= 1'h0;
        lag <= 4'h9;
        $display("test capture done");
    endtask

    task t_enable;
        parallel_io_master_port_pkg::drive_cond_t c;
        pins <= 16'h0000;
        @(posedge clk_i);
        for (int k = 0; k < 4; k++)
        begin
            c = GOOD;
            case (k)
                0: c.error_pending = 1'h1;
                1: c.phase = 3'h3;
                2: c.dc_bus_ok = 1'h0;
                default: c.device_status = 16'h0000;
            endcase
            cond <= c;
            en_edge;
            check(32'(rep.energized), 32'h0);
            cond <= GOOD;
            settle;
            check(32'(rep.energized), 32'h0);
            pins[10] <= 1'h0;
            settle;
        end
        en_edge;
        check(32'(rep.energized), 32'h1);
        check(32'(rep.halted), 32'h1);
        check(32'(rep.halt_diagnostic_code), 32'h000A0010);
        check(32'(rep.panel), 32'(parallel_io_master_port_pkg::HALT_PANEL_CODE));
        pins[11] <= 1'h1;
        settle;
        check(32'(rep.halted), 32'h0);
        check(32'(rep.op_mode_active), 32'h1);
        check(32'(rep.panel), 32'(parallel_io_master_port_pkg::RUNNING_PANEL_CODE));
        check(32'(port_out_o), 32'h000000CB);
        wb(1'h1, 8'h08, 32'h0000A500);
        wb(1'h1, 8'h10, 32'h76543222);
        settle;
        check(32'(port_out_o), 32'h0000A5C8);
        rd_chk(8'h08, 32'h0000A5C8);
        wb(1'h1, 8'h10, 32'h76543210);
        // Moving the enable function to an idle line must drop the drive.
        wb(1'h1, 8'h0C, 32'h00000CBD);
        settle;
        check(32'(rep.energized), 32'h0);
        wb(1'h1, 8'h0C, 32'h00000CBA);
        settle;
        check(32'(rep.energized), 32'h0);
        $display("test enable done");
    endtask

    task t_clear;
        int cnt;
        cnt = 0;
        cond.error_pending <= 1'h1;
        pins[12] <= 1'h0;
        settle;
        check(32'(rep.energized), 32'h0);
        pins[12] <= 1'h1;
        repeat (100)
        begin
            @(posedge clk_i);
            if (clr_o === 1'h1)
                cnt++;
        end
        check(32'(cnt), 32'h1);
        // The drive core clears every pending error on the pulse.
        cond.error_pending <= 1'h0;
        pins[12] <= 1'h0;
        settle;
        $display("test clear done");
    endtask

    task t_deact;
        wb(1'h1, 8'h00, 32'h00000002);
        rd_chk(8'h00, 32'h00000002);
        supply <= 1'h0;
        settle;
        check(32'(fault_o), 32'h0);
        check(32'(port_out_o), 32'h0);
        rd_chk(8'h08, 32'h0000A500);
        wb(1'h1, 8'h04, 32'h00001234);
        rd_chk(8'h04, 32'h00001234);
        wb(1'h1, 8'h40, 32'h0000FFFF);
        rd_chk(8'h40, 32'h00000000);
        wb(1'h1, 8'h00, 32'h0000000F);
        rd_chk(8'h00, 32'h0000000F);
        wait_fault(1'h1);
        $display("test deactivate done");
    endtask

    initial
    begin
        fail_count = 0;
        comparisons = 0;
        rst_i <= 1'h1;
        {cyc, stb, we, supply, basic} <= 5'h00;
        adr <= 8'h00;
        sel <= 4'h0;
        wdat <= 32'h00000000;
        lag <= 4'h0;
        pins <= 16'h0000;
        cond <= GOOD;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        t_reset;
        t_capture;
        t_enable;
        t_clear;
        t_deact;
        stop_test;
    end
endmodule
`default_nettype wire
